// file: rtl/counter_measure_pkg.sv
// constants and types for the counter measurement channel
package counter_measure_pkg;
	// ==========================================
	// clock and tick sizes
	localparam int CLK_PERIOD_PS = 50000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK0_PS = 20830;
	localparam int TICK1_PS = 208300;
	localparam int TICK2_PS = 2083300;
	localparam int TICK3_PS = 20833300;
	localparam int TICK0_CYC = (TICK0_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TICK1_CYC = (TICK1_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TICK2_CYC = (TICK2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TICK3_CYC = (TICK3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TICK_W = 9;
	// ==========================================
	// period multipliers
	localparam logic [1:0] period_mult_one = 2'h0;
	localparam logic [1:0] period_mult_ten = 2'h1;
	localparam logic [1:0] period_mult_hundred = 2'h2;
	localparam logic [1:0] period_mult_thousand = 2'h3;
	localparam int PER_W = 10;
	// ==========================================
	// debounce times, shortest first
	localparam int DEB_W = 20;
	typedef logic [DEB_W-1:0] deb_tab_t [16];
	localparam int DEB_NS [16] = '{500, 1000, 2000, 5000, 10000, 20000, 50000, 100000,
		200000, 500000, 1000000, 2000000, 5000000, 10000000, 20000000, 25500000};
	// ==========================================
	// modes and states
	typedef enum logic [1:0] {MODE_PERIOD = 2'b00, MODE_PULSE = 2'b01,
		MODE_TIMING = 2'b10, MODE_OFF = 2'b11} mode_e;
	typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} meas_e;
	localparam logic [31:0] RESULT_RST = 32'h0;

	// cycle counts of the debounce times, least time rounded up
	function automatic deb_tab_t deb_cycles();
		deb_tab_t t;
		for (int i = 0; i < 16; i++)
		begin
			t[i] = DEB_W'((DEB_NS[i] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
		end
		return t;
	endfunction
endpackage

// file: rtl/counter_measure_debounce.sv
// one counter channel: debounce front end and period, pulse and timing measurement
`timescale 1ns/1ps
module counter_measure_debounce
	import counter_measure_pkg::*;
#(
	parameter int CNT_W = 32,
	parameter deb_tab_t DEB_CYC = deb_cycles()
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RST_B,
	// channel pins
	input wire logic MEASURED_INPUT,
	input wire logic GATE_INPUT,
	// measurement setup
	input wire logic [1:0] MODE,
	input wire logic [1:0] PERIOD_MULT,
	input wire logic [1:0] TICK_SEL,
	input wire logic GATE_EN,
	input wire logic GATE_FALL,
	// debounce setup
	input wire logic INVERT,
	input wire logic DEB_BYPASS,
	input wire logic DEB_BEFORE,
	input wire logic [3:0] DEB_TIME,
	// results
	output logic [CNT_W-1:0] RESULT,
	output logic RESULT_STROBE,
	output logic FILTERED_INPUT
);

	// last tick-prescaler count for a tick selection
	function automatic logic [TICK_W-1:0] tick_last(input logic [1:0] sel);
		unique case (sel)
			2'h0: return TICK_W'(TICK0_CYC - 1);
			2'h1: return TICK_W'(TICK1_CYC - 1);
			2'h2: return TICK_W'(TICK2_CYC - 1);
			2'h3: return TICK_W'(TICK3_CYC - 1);
		endcase
	endfunction

	// last period index for a multiplier
	function automatic logic [PER_W-1:0] mult_last(input logic [1:0] sel);
		unique case (sel)
			period_mult_one: return PER_W'(0);
			period_mult_ten: return PER_W'(9);
			period_mult_hundred: return PER_W'(99);
			period_mult_thousand: return PER_W'(999);
		endcase
	endfunction

	// ==========================================
	// debounce front end
	logic inv;
	logic prev_in_q, prev_in_d;
	logic [DEB_W-1:0] stab_q, stab_d;
	logic filt_q, filt_d;
	logic [DEB_W-1:0] lim;
	logic quiet;

	assign inv = MEASURED_INPUT ^ INVERT;
	assign lim = DEB_CYC[DEB_TIME];
	assign quiet = stab_q >= lim - DEB_W'(1);

	// stability counter and filter output
	always_comb
	begin
		prev_in_d = inv;
		stab_d = stab_q;
		filt_d = filt_q;
		if (inv != prev_in_q)
			stab_d = '0;
		else if (stab_q != '1)
			stab_d = stab_q + DEB_W'(1);
		if (DEB_BYPASS)
			filt_d = inv;
		else if (DEB_BEFORE)
		begin
			if (inv != filt_q && quiet)
				filt_d = inv;
		end
		else if (inv == prev_in_q && inv != filt_q && quiet)
			filt_d = inv;
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			prev_in_q <= 1'b0;
			stab_q <= '0;
			filt_q <= 1'b0;
		end
		else
		begin
			prev_in_q <= prev_in_d;
			stab_q <= stab_d;
			filt_q <= filt_d;
		end
	end

	// ==========================================
	// edges and tick
	logic fprev_q, gprev_q;
	logic [TICK_W-1:0] tick_q, tick_d;
	logic fr, ff, gate_e, tick_p;

	assign fr = filt_q && !fprev_q;
	assign ff = !filt_q && fprev_q;
	assign gate_e = GATE_FALL ? (gprev_q && !GATE_INPUT) : (!gprev_q && GATE_INPUT);
	assign tick_p = tick_q >= tick_last(TICK_SEL);

	// ==========================================
	// measurement state
	mode_e mode_q, mode_d;
	meas_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, result_q, result_d;
	logic [PER_W-1:0] per_q, per_d;
	logic strobe_d, strobe_q;
	logic cfg_chg, cnt_clr, cnt_en;

	assign cfg_chg = mode_e'(MODE) != mode_q;
	assign cnt_en = state_q == ST_RUN && tick_p
		&& (mode_q == MODE_TIMING || !GATE_EN || GATE_INPUT);

	// sequencing of clears and latches per mode
	always_comb
	begin
		mode_d = mode_e'(MODE);
		state_d = state_q;
		per_d = per_q;
		result_d = result_q;
		strobe_d = 1'b0;
		cnt_clr = 1'b0;
		if (cfg_chg)
		begin
			state_d = ST_IDLE;
			result_d = CNT_W'(RESULT_RST);
			cnt_clr = 1'b1;
		end
		else
		begin
			unique case (mode_q)
				MODE_PERIOD:
				begin
					if (fr && state_q == ST_IDLE)
					begin
						state_d = ST_RUN;
						per_d = '0;
						cnt_clr = 1'b1;
					end
					else if (fr && per_q == mult_last(PERIOD_MULT))
					begin
						result_d = cnt_q;
						strobe_d = 1'b1;
						per_d = '0;
						cnt_clr = 1'b1;
					end
					else if (fr)
						per_d = per_q + PER_W'(1);
				end
				MODE_PULSE:
				begin
					if (state_q == ST_IDLE && fr)
					begin
						state_d = ST_RUN;
						cnt_clr = 1'b1;
					end
					else if (state_q == ST_RUN && ff)
					begin
						result_d = cnt_q;
						strobe_d = 1'b1;
						state_d = ST_IDLE;
						cnt_clr = 1'b1;
					end
				end
				MODE_TIMING:
				begin
					if (fr)
					begin
						state_d = ST_RUN;
						cnt_clr = 1'b1;
					end
					else if (state_q == ST_RUN && gate_e)
					begin
						result_d = cnt_q;
						strobe_d = 1'b1;
						state_d = ST_IDLE;
						cnt_clr = 1'b1;
					end
				end
				MODE_OFF:
					state_d = ST_IDLE;
			endcase
		end
		cnt_d = cnt_clr ? '0 : (cnt_en ? cnt_q + CNT_W'(1) : cnt_q);
		tick_d = (cnt_clr || tick_p) ? '0 : tick_q + TICK_W'(1);
	end

	always_ff @(posedge CLOCK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			fprev_q <= 1'b0;
			gprev_q <= 1'b0;
			tick_q <= '0;
			mode_q <= MODE_PERIOD;
			state_q <= ST_IDLE;
			cnt_q <= '0;
			per_q <= '0;
			result_q <= CNT_W'(RESULT_RST);
			strobe_q <= 1'b0;
		end
		else
		begin
			fprev_q <= filt_q;
			gprev_q <= GATE_INPUT;
			tick_q <= tick_d;
			mode_q <= mode_d;
			state_q <= state_d;
			cnt_q <= cnt_d;
			per_q <= per_d;
			result_q <= result_d;
			strobe_q <= strobe_d;
		end
	end

	// outputs straight from flops
	assign RESULT = result_q;
	assign RESULT_STROBE = strobe_q;
	assign FILTERED_INPUT = filt_q;

	// ==========================================
	// assertions
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);

	sequence s_tick1;
		tick_p && TICK_SEL == 2'h1 && !cnt_clr;
	endsequence
	sequence s_hold1;
		(TICK_SEL == 2'h1 && !cnt_clr)[*4];
	endsequence

	a_tick_spacing: assert property (s_tick1 ##1 s_hold1 |=> tick_p && !$past(tick_p))
		else $error("tick of size one not five cycles apart");
	a_tick_count: assert property (!cnt_clr && !tick_p |=> $stable(cnt_q))
		else $error("count moved between ticks");
	a_filter_quiet: assert property (!$past(DEB_BYPASS) && $stable(DEB_TIME)
		&& $changed(filt_q) |-> $past(stab_q) >= $past(lim) - DEB_W'(1))
		else $error("filter changed before debounce time");
	a_after_stable: assert property (!$past(DEB_BYPASS) && !$past(DEB_BEFORE)
		&& $changed(filt_q) |-> $past(inv == prev_in_q))
		else $error("after-stable output moved on an edge");
	a_before_follow: assert property (!DEB_BYPASS && DEB_BEFORE && inv != prev_in_q
		&& inv != filt_q && quiet |=> filt_q == $past(inv))
		else $error("before-stable output did not follow quiet edge");
	a_bypass_follow: assert property (DEB_BYPASS |=> filt_q == $past(inv))
		else $error("bypass did not pass input");
	a_period_mult: assert property (strobe_q && mode_q == MODE_PERIOD
		|-> $past(per_q) == mult_last($past(PERIOD_MULT)))
		else $error("period latched at wrong period count");
	a_period_edge: assert property (strobe_q && mode_q == MODE_PERIOD |-> $past(fr))
		else $error("period latched without a measured edge");
	a_pulse_latch: assert property (mode_q == MODE_PULSE && state_q == ST_RUN && ff
		&& !cfg_chg |=> strobe_q && result_q == $past(cnt_q) && cnt_q == '0)
		else $error("pulse width not latched and cleared");
	a_timing_latch: assert property (mode_q == MODE_TIMING && state_q == ST_RUN && gate_e
		&& !fr && !cfg_chg |=> strobe_q && result_q == $past(cnt_q) && state_q == ST_IDLE)
		else $error("gate edge did not latch timing count");
	a_timing_restart: assert property (mode_q == MODE_TIMING && fr && !cfg_chg
		|=> state_q == ST_RUN && cnt_q == '0)
		else $error("measured edge did not restart timing");
	a_result_hold: assert property ($changed(result_q) |-> strobe_q || $past(cfg_chg))
		else $error("result changed without a measurement");
	a_cfg_zero: assert property (cfg_chg |=> result_q == RESULT_RST)
		else $error("result not zero after mode change");
	a_gate_hold: assert property (GATE_EN && !GATE_INPUT && mode_q != MODE_TIMING
		&& !cnt_clr |=> $stable(cnt_q))
		else $error("count moved while gate low");
endmodule

// file: dv/pin_src.sv
// pulse source model driving the measured and gate pins
`timescale 1ns/1ps
module pin_src (
	// clock
	input wire logic clk,
	// pins
	output logic meas,
	output logic gate
);
	// pins start low
	initial
	begin
		meas = 1'b0;
		gate = 1'b0;
	end
	// hold the measured pin at v for n cycles
	task automatic m(input logic v, input int n);
		meas <= v;
		repeat (n) @(posedge clk);
	endtask
	// hold the gate pin at v for n cycles
	task automatic g(input logic v, input int n);
		gate <= v;
		repeat (n) @(posedge clk);
	endtask
endmodule

// file: dv/tb_counter_measure_debounce.sv
// self-checking testbench for the counter measurement channel
`timescale 1ns/1ps
module tb_counter_measure_debounce;
	import counter_measure_pkg::*;
	// ==========================================
	// signals
	logic clk, rst_b, meas, gate, gate_en, gate_fall, inv, byp, bef, stb, filt;
	logic [1:0] mode, mult, tsel;
	logic [3:0] dtime;
	logic [31:0] res, r;
	int err_count, n_checks, w, d, t;
	// short debounce table, index + 2 cycles
	function automatic deb_tab_t mk();
		deb_tab_t x;
		for (int i = 0; i < 16; i++)
			x[i] = DEB_W'(i + 2);
		return x;
	endfunction
	function automatic int tk(logic [1:0] s);
		return s == 2'h0 ? TICK0_CYC : s == 2'h1 ? TICK1_CYC : s == 2'h2 ? TICK2_CYC : TICK3_CYC;
	endfunction
	// whole ticks over n cycles from clear to latch; a tick ending on the latch edge is dropped
	function automatic int ticks(int n, logic [1:0] s);
		return (n - 1) / tk(s);
	endfunction
	// ==========================================
	// design and pin source
	counter_measure_debounce #(.CNT_W(32), .DEB_CYC(mk())) i_counter_measure_debounce (
		.CLOCK(clk), .RST_B(rst_b), .MEASURED_INPUT(meas), .GATE_INPUT(gate),
		.MODE(mode), .PERIOD_MULT(mult), .TICK_SEL(tsel), .GATE_EN(gate_en),
		.GATE_FALL(gate_fall), .INVERT(inv), .DEB_BYPASS(byp), .DEB_BEFORE(bef),
		.DEB_TIME(dtime), .RESULT(res), .RESULT_STROBE(stb), .FILTERED_INPUT(filt));
	pin_src i_pin_src (.clk(clk), .meas(meas), .gate(gate));
	// ==========================================
	// clock and time-zero values
	initial
	begin
		{clk, rst_b, gate_en, gate_fall, inv, bef, mult, tsel, dtime} = '0;
		{byp, mode} = 3'h7;
		forever #25 clk = ~clk;
	end
	// ==========================================
	// helpers
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s exp %0h got %0h", nm, e, s);
		end
	endtask
	// wait for a result strobe, bounded
	task automatic ws();
		int k;
		for (k = 0; k < 20000 && stb !== 1'b1; k++)
			@(negedge clk);
		if (stb !== 1'b1)
		begin
			err_count++;
			end_sim();
		end
	endtask
	// filter output checked between edges
	task automatic cf(input logic e);
		@(negedge clk);
		chk("filt", {31'h0, e}, {31'h0, filt});
		@(posedge clk);
	endtask
	task automatic cfg(input logic [1:0] md, input logic [1:0] ts, input logic i, input logic b);
		@(posedge clk);
		mode <= md;
		tsel <= ts;
		inv <= i;
		byp <= b;
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		void'($urandom(32'he58a));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		// pulse width at every tick size, gated on odd passes
		for (int s = 0; s < 4; s++)
		begin
			t = $urandom_range(1, 0);
			w = $urandom_range(900, 40);
			// gated passes hold the gate low for whole ticks, so the loss is exact
			d = s[0] ? tk(s[1:0]) * $urandom_range(2, 1) : $urandom_range(20, 1);
			cfg(2'h1, s[1:0], t[0], 1'b1);
			gate_en <= s[0];
			i_pin_src.m(t[0], 10);
			i_pin_src.m(~t[0], 10);
			i_pin_src.g(1'b0, d);
			i_pin_src.g(1'b1, w - 10);
			i_pin_src.m(t[0], 0);
			ws();
			chk("pulse", ticks(w + d, s[1:0]) - (s[0] ? d / tk(s[1:0]) : 0), res);
		end
		// period with every multiplier
		for (int s = 0; s < 4; s++)
		begin
			w = $urandom_range(6, 2);
			t = $urandom_range(1, 0);
			d = s == 0 ? 1 : s == 1 ? 10 : s == 2 ? 100 : 1000;
			// off first, so the first rise arms a fresh measurement
			cfg(2'h3, 2'h0, 1'b0, 1'b1);
			cfg(2'h0, t[1:0], 1'b0, 1'b1);
			mult <= s[1:0];
			i_pin_src.m(1'b0, 5);
			repeat (d)
			begin
				i_pin_src.m(1'b1, w);
				i_pin_src.m(1'b0, w);
			end
			i_pin_src.m(1'b1, 0);
			ws();
			chk("period", ticks(d * 2 * w, t[1:0]), res);
		end
		// timing: zero first, second edge restarts, stray gate edge ignored
		t = $urandom_range(1, 0);
		d = $urandom_range(60, 8);
		cfg(2'h2, 2'h0, 1'b0, 1'b1);
		gate_fall <= t[0];
		i_pin_src.g(t[0], 0);
		i_pin_src.m(1'b0, 5);
		chk("timing zero", 32'h0, res);
		i_pin_src.m(1'b1, 10);
		i_pin_src.m(1'b0, 3);
		i_pin_src.m(1'b1, d);
		i_pin_src.g(~t[0], 0);
		ws();
		r = res;
		// measured edge reaches the counter two cycles after the pin, the gate edge one cycle after
		chk("timing", d - 2, r);
		@(posedge clk);
		i_pin_src.g(t[0], 5);
		i_pin_src.g(~t[0], 5);
		chk("timing hold", r, res);
		// debounce modes: one-cycle glitch, then a steady level
		for (int s = 0; s < 2; s++)
		begin
			d = $urandom_range(15, 4);
			cfg(2'h3, 2'h0, 1'b0, 1'b0);
			bef <= s[0];
			dtime <= d[3:0];
			i_pin_src.m(1'b0, d + 8);
			i_pin_src.m(1'b1, 1);
			i_pin_src.m(1'b0, 2);
			cf(s[0]);
			i_pin_src.m(1'b0, d + 6);
			cf(1'b0);
			i_pin_src.m(1'b1, d + 6);
			cf(1'b1);
		end
		// bypass follows the pin a cycle later, inverted on request
		for (int s = 0; s < 8; s++)
		begin
			t = $urandom();
			cfg(2'h3, 2'h0, t[1], 1'b1);
			dtime <= 4'hf;
			i_pin_src.m(t[0], 1);
			cf(t[0] ^ t[1]);
		end
		end_sim();
	end
endmodule
